/* hw/fxr_cfg.svh */
// Constants of the extended read status register: opcodes, bit positions and reset values.
`ifndef FXR_CFG_SVH
`define FXR_CFG_SVH

`define FXR_OP_SET_NV     8'h85
`define FXR_OP_SET_V      8'h83
`define FXR_OP_CLEAR      8'h82
`define FXR_OP_READ       8'h81

`define FXR_BIT_BUSY      0
`define FXR_BIT_PROT      1
`define FXR_BIT_PERR      2
`define FXR_BIT_EERR      3
`define FXR_BIT_RSVD      4
`define FXR_DS_LSB        5
`define FXR_DS_MSB        7

`define FXR_REG_RESET     8'hf0
`define FXR_DS_RESET      3'h7
`define FXR_WRITABLE_MASK 8'he0
`define FXR_RSVD_VALUE    1'h1

`define FXR_BYTE_BITS     5'h08
`define FXR_CMD_BITS      5'h10
`define FXR_WRAP_COUNT    5'h09

`endif

/* hw/fxr_pkg.sv */
// Types shared by the extended read status register and its users.
package fxr_pkg;

    typedef enum logic [2:0] {
        FXR_OP_PAGE,
        FXR_OP_INFO_PROG,
        FXR_OP_FUNC_REG,
        FXR_OP_NV_REG,
        FXR_OP_STATUS_WRITE,
        FXR_OP_ERASE,
        FXR_OP_INFO_ERASE,
        FXR_OP_CHIP_ERASE
    } fxr_op_kind_t;

    typedef struct packed {
        logic         valid;
        fxr_op_kind_t kind;
        logic         fail;
        logic         erase_phase_fail;
        logic         prog_phase_fail;
        logic         target_protected;
    } fxr_op_report_t;

    typedef struct packed {
        logic eerr;
        logic perr;
        logic prot;
    } fxr_err_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data;
    } fxr_cmd_t;

endpackage

/* hw/fxr_sync.sv */
// Two-flop level synchroniser for signals entering a clock domain.
`timescale 1ns/100ps
`default_nettype none

module fxr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,    // Destination clock.
    input  wire logic [WIDTH-1:0] async_i,  // Level from another domain.
    output logic      [WIDTH-1:0] sync_o    // Synchronised level.
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    if (WIDTH < 1) begin : g_width_check
        $error("fxr_sync needs WIDTH of at least one.");
    end

    always_ff @(posedge clk_i) begin
        stage1_q <= async_i;
        stage2_q <= stage1_q;
    end

    assign sync_o = stage2_q;

endmodule

`default_nettype wire

/* hw/fxr_ext_read_reg.sv */
// Extended read status register with its serial command port.
// Functional notes
// - Three drive bits select output strength
// - Opcode 85h writes both copies, 83h only the volatile one
// - Set commands never touch four status bits
// - Bit four reserved; reset reads f0
// - Bit zero mirrors main busy bit
// - Protected or locked target sets protection flag
// - Program or register write failure sets program flag
// - Erase or register write failure sets erase flag
// - Protected page program sets program and protection
// - Locked info row program sets both flags
// - Register update phases set matching flags
// - Locked status write sets protection and erase
// - Erase failure or protected erase flags errors
// - Chip erase with protect bits flags both
// - One-time bits only change zero to one
// - Writes drop read-only bit positions silently
// - Error flags stick until clear or reset
// - Error flags never block command acceptance
// - Writes need the write latch set
`include "fxr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module fxr_ext_read_reg
    import fxr_pkg::*;
(
    input  wire logic           clk_i,               // Core clock, 250 MHz.
    input  wire logic           reset_i,             // Power-on reset, active high.
    input  wire logic           soft_reset_i,        // Software reset pulse.
    input  wire logic           busy_i,              // Main status busy bit.
    input  wire logic           write_latch_bit_i,   // Write enable latch.
    input  wire logic           status_lock_bit_i,   // Status register lock bit.
    input  wire logic           wp_n_i,              // Write-protect pin, active low.
    input  wire logic [3:0]     block_protect_bits_i, // Block protect bits.
    input  wire fxr_op_report_t op_report_i,         // Finished operation report.
    input  wire logic [7:0]     func_otp_old_i,      // Current one-time bits.
    input  wire logic [7:0]     func_otp_new_i,      // Requested one-time bits.
    input  wire logic           sck_i,               // Serial link clock.
    input  wire logic           cs_n_i,              // Chip select, active low.
    input  wire logic           mosi_i,              // Serial data in.
    output logic                miso_o,              // Serial data out.
    output logic                miso_oe_n_o,         // Data out enable, low drives.
    output logic [7:0]          ext_read_status_o,   // Register image.
    output logic [2:0]          drive_strength_o,    // Active drive code.
    output logic [3:0]          drive_eighths_o,     // Strength in eighths, 0 reserved.
    output logic                nv_write_o,          // Non-volatile update pulse.
    output logic [7:0]          nv_data_o,           // Non-volatile update image.
    output logic [7:0]          func_otp_merged_o    // Allowed one-time bit image.
);

    function automatic logic [7:0] merge_writable(input logic [7:0] old_v,
                                                  input logic [7:0] new_v);
        merge_writable = (old_v & ~`FXR_WRITABLE_MASK) | (new_v & `FXR_WRITABLE_MASK);
    endfunction

    function automatic logic [3:0] drive_eighths(input logic [2:0] code);
        case (code)
            3'h1:    drive_eighths = 4'h1;
            3'h2:    drive_eighths = 4'h2;
            3'h3:    drive_eighths = 4'h3;
            3'h5:    drive_eighths = 4'h6;
            3'h6:    drive_eighths = 4'h8;
            3'h7:    drive_eighths = 4'h4;
            default: drive_eighths = 4'h0;
        endcase
    endfunction

    // Link domain. The frame's chip select clears all of it but the command word and the status synchroniser, since the clock stops between frames.
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] opcode_q;
    logic [7:0] opcode_d;
    logic       cmd_valid_q;
    logic       cmd_valid_d;
    fxr_cmd_t   cmd_word_q;
    logic [7:0] rd_shift_q;
    logic [7:0] rd_shift_d;
    logic       drive_q;
    logic       drive_d;
    logic [7:0] ext_link;
    logic       capture;

    always_comb begin
        shift_d     = {shift_q[6:0], mosi_i};
        cnt_d       = (cnt_q == `FXR_CMD_BITS) ? `FXR_WRAP_COUNT : cnt_q + 5'h01;
        opcode_d    = (cnt_q == 5'h07) ? shift_d : opcode_q;
        capture     = 1'b0;
        if (!cmd_valid_q) begin
            if (cnt_q == 5'h07 && shift_d == `FXR_OP_CLEAR) begin
                capture = 1'b1;
            end else if (cnt_q == 5'h0f && (opcode_q == `FXR_OP_SET_NV ||
                                            opcode_q == `FXR_OP_SET_V)) begin
                capture = 1'b1;
            end
        end
        cmd_valid_d = cmd_valid_q | capture;
    end

    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            cnt_q       <= 5'h00;
            shift_q     <= 8'h00;
            opcode_q    <= 8'h00;
            cmd_valid_q <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            shift_q     <= shift_d;
            opcode_q    <= opcode_d;
            cmd_valid_q <= cmd_valid_d;
        end
    end

    // The word is held past the frame so the core can read it after the valid level crosses.
    always_ff @(posedge sck_i) begin
        if (capture) begin
            cmd_word_q <= (cnt_q == 5'h07) ? {shift_d, 8'h00} : {opcode_q, shift_d};
        end
    end

    // The status image is sampled afresh from the start of each frame's clock.
    fxr_sync #(.WIDTH(8)) u_ext_to_link (
        .clk_i   (sck_i),
        .async_i (ext_read_status_o),
        .sync_o  (ext_link)
    );

    always_comb begin
        rd_shift_d = {rd_shift_q[6:0], 1'b0};
        drive_d    = drive_q;
        if (opcode_q == `FXR_OP_READ && cnt_q[2:0] == 3'h0 && cnt_q != 5'h00) begin
            rd_shift_d = ext_link;
            drive_d    = 1'b1;
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rd_shift_q <= 8'h00;
            drive_q    <= 1'b0;
        end else begin
            rd_shift_q <= rd_shift_d;
            drive_q    <= drive_d;
        end
    end

    assign miso_o      = rd_shift_q[7];
    assign miso_oe_n_o = ~drive_q;

    // Core domain.
    logic       cmd_valid_s;
    logic       wp_n_s;
    logic       seen_q;
    logic       seen_d;
    logic       cmd_go;
    logic       wr_go;
    logic       clr_go;
    fxr_err_t   err_q;
    fxr_err_t   err_d;
    fxr_err_t   err_set;
    logic [2:0] ds_v_q;
    logic [2:0] ds_v_d;
    logic [2:0] ds_nv_q;
    logic [2:0] ds_nv_d;
    logic [7:0] ext_q;
    logic [7:0] ext_d;
    logic       nv_write_q;
    logic       nv_write_d;
    logic [7:0] nv_data_q;
    logic [7:0] nv_data_d;
    logic [7:0] otp_q;
    logic [7:0] otp_d;
    logic [7:0] wr_image;

    fxr_sync #(.WIDTH(1)) u_cmd_to_core (
        .clk_i   (clk_i),
        .async_i (cmd_valid_q),
        .sync_o  (cmd_valid_s)
    );

    fxr_sync #(.WIDTH(1)) u_wp_sync (
        .clk_i   (clk_i),
        .async_i (wp_n_i),
        .sync_o  (wp_n_s)
    );

    // Commands are taken whatever the error flags hold.
    assign cmd_go = cmd_valid_s & ~seen_q;
    assign clr_go = cmd_go & (cmd_word_q.opcode == `FXR_OP_CLEAR);
    assign wr_go  = cmd_go & write_latch_bit_i &
                    (cmd_word_q.opcode == `FXR_OP_SET_NV || cmd_word_q.opcode == `FXR_OP_SET_V);

    always_comb begin
        err_set = '0;
        if (op_report_i.valid) begin
            case (op_report_i.kind)
                FXR_OP_PAGE, FXR_OP_INFO_PROG: begin
                    err_set.perr = op_report_i.fail | op_report_i.target_protected;
                    err_set.prot = op_report_i.target_protected;
                end
                FXR_OP_FUNC_REG: begin
                    err_set.perr = op_report_i.fail;
                end
                FXR_OP_NV_REG, FXR_OP_STATUS_WRITE: begin
                    err_set.eerr = op_report_i.erase_phase_fail;
                    err_set.perr = op_report_i.prog_phase_fail;
                    if (op_report_i.kind == FXR_OP_STATUS_WRITE &&
                        status_lock_bit_i && !wp_n_s) begin
                        err_set.eerr = 1'b1;
                        err_set.prot = 1'b1;
                    end
                end
                FXR_OP_ERASE, FXR_OP_INFO_ERASE, FXR_OP_CHIP_ERASE: begin
                    err_set.eerr = op_report_i.fail | op_report_i.target_protected;
                    err_set.prot = op_report_i.target_protected;
                    if (op_report_i.kind == FXR_OP_CHIP_ERASE &&
                        block_protect_bits_i != 4'h0) begin
                        err_set.eerr = 1'b1;
                        err_set.prot = 1'b1;
                    end
                end
                default: err_set = '0;
            endcase
        end
    end

    always_comb begin
        seen_d     = cmd_valid_s;
        // A new error in the clearing cycle survives the clear.
        err_d      = ((clr_go | soft_reset_i) ? fxr_err_t'(3'h0) : err_q) | err_set;
        wr_image   = merge_writable(ext_q, cmd_word_q.data);
        ds_v_d     = ds_v_q;
        ds_nv_d    = ds_nv_q;
        nv_write_d = 1'b0;
        nv_data_d  = nv_data_q;
        if (soft_reset_i) begin
            ds_v_d = ds_nv_q;
        end else if (wr_go) begin
            ds_v_d = wr_image[`FXR_DS_MSB:`FXR_DS_LSB];
            if (cmd_word_q.opcode == `FXR_OP_SET_NV) begin
                ds_nv_d    = wr_image[`FXR_DS_MSB:`FXR_DS_LSB];
                nv_write_d = 1'b1;
                nv_data_d  = wr_image;
            end
        end
        ext_d = {ds_v_d, `FXR_RSVD_VALUE, err_d.eerr, err_d.perr, err_d.prot, busy_i};
        otp_d = func_otp_old_i | func_otp_new_i;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            seen_q     <= 1'b0;
            err_q      <= '0;
            ds_v_q     <= `FXR_DS_RESET;
            ds_nv_q    <= `FXR_DS_RESET;
            ext_q      <= `FXR_REG_RESET;
            nv_write_q <= 1'b0;
            nv_data_q  <= `FXR_REG_RESET;
            otp_q      <= 8'h00;
        end else begin
            seen_q     <= seen_d;
            err_q      <= err_d;
            ds_v_q     <= ds_v_d;
            ds_nv_q    <= ds_nv_d;
            ext_q      <= ext_d;
            nv_write_q <= nv_write_d;
            nv_data_q  <= nv_data_d;
            otp_q      <= otp_d;
        end
    end

    assign ext_read_status_o = ext_q;
    assign drive_strength_o  = ds_v_q;
    assign drive_eighths_o   = drive_eighths(ds_v_q);
    assign nv_write_o        = nv_write_q;
    assign nv_data_o         = nv_data_q;
    assign func_otp_merged_o = otp_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_BUSY_MIRROR: assert property (!$past(reset_i) |-> ext_q[0] == $past(busy_i))
        else $error("Busy mirror does not follow busy input.");
    AST_RSVD_ONE: assert property (ext_read_status_o[4] == 1'b1)
        else $error("Reserved bit reads zero.");
    AST_RESET_IMAGE: assert property (disable iff (1'b0) $past(reset_i) |-> ext_q == 8'hf0)
        else $error("Register image after reset is wrong.");
    AST_STICKY: assert property (err_q.perr && !clr_go && !soft_reset_i |=> err_q.perr)
        else $error("Program error flag dropped without a clear.");
    AST_CLEAR: assert property (clr_go && !op_report_i.valid |=>
                                err_q == 3'h0 && ext_q[3:1] == 3'h0)
        else $error("Clear did not empty the error flags.");
    AST_CLEAR_KEEPS_DS: assert property (clr_go && !soft_reset_i |=> $stable(ds_v_q))
        else $error("Clear altered drive strength.");
    AST_SET_KEEPS_FLAGS: assert property (wr_go && !op_report_i.valid && !soft_reset_i |=>
                                          $stable(err_q))
        else $error("Set command altered error flags.");
    AST_NO_LATCH: assert property (cmd_go && !write_latch_bit_i && !soft_reset_i |=>
                                   $stable(ds_v_q))
        else $error("Write without latch changed drive strength.");
    AST_DS_WRITE: assert property (wr_go && !soft_reset_i |=>
                                   ds_v_q == $past(cmd_word_q.data[7:5]))
        else $error("Set command did not load drive strength.");
    AST_CHIP_BP: assert property (op_report_i.valid && block_protect_bits_i != 4'h0 &&
                                  op_report_i.kind == FXR_OP_CHIP_ERASE |=>
                                  err_q.eerr && err_q.prot && ext_q[3] && ext_q[1])
        else $error("Chip erase under protect bits missed its flags.");
    AST_PAGE_PROT: assert property (op_report_i.valid && op_report_i.kind == FXR_OP_PAGE &&
                                    op_report_i.target_protected |=> err_q.perr && err_q.prot)
        else $error("Protected page program missed its flags.");
    AST_STATUS_LOCK: assert property (op_report_i.valid && status_lock_bit_i && !wp_n_s &&
                                      op_report_i.kind == FXR_OP_STATUS_WRITE |=>
                                      err_q.eerr && err_q.prot)
        else $error("Locked status write missed its flags.");

    COV_NV_WRITE: cover property (wr_go ##1 nv_write_q);
    COV_CLEAR_AFTER_ERR: cover property (err_q.eerr ##[1:20] clr_go);
    COV_SET_AND_CLEAR: cover property (clr_go && op_report_i.valid);

endmodule

`default_nettype wire

/* testbench/fxr_host.sv */
// Serial host model that frames commands on the link and samples read data.
`timescale 1ns/100ps
`default_nettype none

module fxr_host (
    output logic      sck_o,       // Link clock, still between frames.
    output logic      cs_n_o,      // Chip select, active low.
    output logic      mosi_o,      // Serial data to the device.
    input  wire logic miso_i,      // Serial data from the device.
    input  wire logic miso_oe_n_i  // Low while the device drives.
);
    logic      last_q;
    wire logic line_w;

    // A released line shows the inverse of its last level, so stale data never matches.
    assign line_w = miso_oe_n_i ? ~last_q : miso_i;

    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
        last_q = 1'b0;
        // The link logic has no other reset, so a real rising select is made at the start.
        #1 cs_n_o = 1'b1;
    end

    always @(posedge sck_o) begin
        last_q <= line_w;
    end

    // Sends the first n bits of bits; read data is taken on rising edges 9 to 16.
    task automatic frame(input logic [15:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        #14 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi_o = bits[15-i];
            #32 sck_o = 1'b1;
            if (i >= 8) begin
                rd = {rd[6:0], line_w};
            end
            #32 sck_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #32;
    endtask
endmodule

`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the extended read status register.
`include "fxr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
    import fxr_pkg::*;

    localparam logic [3:0] EIGHTHS [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
    // Report cases: kind, fail, erase phase, program phase, protected, locked, bp, flags.
    localparam logic [11:0] CASES [12] = '{12'h023, 12'h102, 12'h223, 12'h302, 12'h502,
        12'h684, 12'h642, 12'h815, 12'hb04, 12'hc25, 12'he0d, 12'he00};

    logic           clk, reset, soft_reset, busy, write_latch_bit, lock, wp_n;
    logic [3:0]     bp;
    fxr_op_report_t rep;
    logic [7:0]     otp_old, otp_new, ext, nvd, otp_m, rd;
    logic           sck, cs_n, mosi, miso, miso_oe_n, nvw;
    logic [2:0]     ds;
    logic [3:0]     eighths;
    logic [11:0]    c;
    int             error_cnt, n_compared, cycles, nv_pulses;

    fxr_ext_read_reg u_dut (.clk_i(clk), .reset_i(reset), .soft_reset_i(soft_reset),
        .busy_i(busy), .write_latch_bit_i(write_latch_bit), .status_lock_bit_i(lock), .wp_n_i(wp_n),
        .block_protect_bits_i(bp), .op_report_i(rep), .func_otp_old_i(otp_old),
        .func_otp_new_i(otp_new), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_n_o(miso_oe_n), .ext_read_status_o(ext),
        .drive_strength_o(ds), .drive_eighths_o(eighths), .nv_write_o(nvw),
        .nv_data_o(nvd), .func_otp_merged_o(otp_m));

    fxr_host u_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
        .miso_oe_n_i(miso_oe_n));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (nvw === 1'b1) begin
            nv_pulses++;
        end
        if (cycles == 40000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        {reset, soft_reset, busy, write_latch_bit, lock, wp_n, bp} = {3'h4, 3'h1, 4'h0};
        rep = '0;
        {otp_old, otp_new} = 16'h0000;
        step(12);
        reset = 1'b0;
        step(3);
        `CHK(ext, `FXR_REG_RESET)
        `CHK(ds, `FXR_DS_RESET)
        `CHK(eighths, 4'h4)
        u_host.frame({`FXR_OP_READ, 8'h00}, 16, rd);
        `CHK(rd, `FXR_REG_RESET)
        write_latch_bit = 1'b1;
        for (int k = 0; k < 8; k++) begin
            u_host.frame({`FXR_OP_SET_V, k[2:0], 5'h1f}, 16, rd);
            step();
            `CHK(ds, k[2:0])
            `CHK(eighths, EIGHTHS[k])
            `CHK(ext, {k[2:0], `FXR_RSVD_VALUE, 4'h0})
        end
        `CHK(nv_pulses, 0)
        write_latch_bit = 1'b0;
        u_host.frame({`FXR_OP_SET_V, 8'h40}, 16, rd);
        step();
        `CHK(ds, 3'h7)
        write_latch_bit = 1'b1;
        // A frame cut short after twelve bits must leave the register alone.
        u_host.frame({`FXR_OP_SET_V, 8'h40}, 12, rd);
        step();
        `CHK(ds, 3'h7)
        u_host.frame({`FXR_OP_SET_NV, 8'ha0}, 16, rd);
        step();
        `CHK(nv_pulses, 1)
        `CHK(nvd, 8'hb0)
        `CHK(ds, 3'h5)
        u_host.frame({`FXR_OP_SET_V, 8'h40}, 16, rd);
        step();
        `CHK(ds, 3'h2)
        soft_reset = 1'b1;
        step();
        soft_reset = 1'b0;
        step(3);
        `CHK(ds, 3'h5)
        for (int i = 0; i < 12; i++) begin
            c = CASES[i];
            lock = c[4];
            wp_n = ~c[4];
            bp = {3'h0, c[3]};
            busy = i[0];
            step(5);
            `CHK(ext[0], busy)
            rep = '{1'b1, fxr_op_kind_t'(c[11:9]), c[8], c[7], c[6], c[5]};
            step();
            rep.valid = 1'b0;
            step(2);
            `CHK(ext[3:1], c[2:0])
            u_host.frame({`FXR_OP_READ, 8'h00}, 16, rd);
            `CHK(rd[3:1], c[2:0])
            u_host.frame({`FXR_OP_CLEAR, 8'h00}, 8, rd);
            step(6);
            `CHK(ext, {3'h5, 1'b1, 3'h0, busy})
        end
        otp_old = 8'h0f;
        otp_new = 8'hf0;
        step(2);
        `CHK(otp_m, 8'hff)
        otp_old = 8'hff;
        otp_new = 8'h00;
        step(2);
        `CHK(otp_m, 8'hff)
        rep = '{1'b1, FXR_OP_PAGE, 1'b0, 1'b0, 1'b0, 1'b1};
        step();
        rep.valid = 1'b0;
        `CHK(ext[3:1], 3'h3)
        soft_reset = 1'b1;
        step();
        soft_reset = 1'b0;
        `CHK(ext[3:1], 3'h0)
        busy = 1'b0;
        rep.valid = 1'b1;
        step();
        rep.valid = 1'b0;
        `CHK(ext[3:1], 3'h3)
        reset = 1'b1;
        step(3);
        reset = 1'b0;
        step(2);
        `CHK(ext, `FXR_REG_RESET)
        `CHK(ds, `FXR_DS_RESET)
        end_sim();
    end
endmodule

`default_nettype wire
